// ==== verilog/pbmc_pkg.sv ====
package pbmc_pkg;

	localparam int           CLK_PERIOD_NS  = 10;
	localparam int           SRST_TIME_NS   = 1000;
	localparam int           SRST_CYCLES    =
		(SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int           LB_DEAD_TIME_US = 500;
	localparam int           LB_DEAD_CYCLES  =
		(LB_DEAD_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int           COL_ON_BIT_TIMES  = 512;
	localparam int           COL_OFF_BIT_TIMES = 4;

	localparam int           SRST_CNT_W     = 8;
	localparam int           DEAD_CNT_W     = 16;
	localparam logic [4:0]   ADDR_CTRL      = 5'h00;

	localparam int           BIT_RESET      = 15;
	localparam int           BIT_LOOPBACK   = 14;
	localparam int           BIT_SPEED      = 13;
	localparam int           BIT_AN_EN      = 12;
	localparam int           BIT_PDOWN      = 11;
	localparam int           BIT_ISOLATE    = 10;
	localparam int           BIT_RESTART    = 9;
	localparam int           BIT_DUPLEX     = 8;
	localparam int           BIT_COLTEST    = 7;

	typedef struct packed {
		logic       reset;
		logic       loopback;
		logic       speed_100;
		logic       an_enable;
		logic       power_down;
		logic       isolate;
		logic       an_restart;
		logic       full_duplex;
		logic       col_test;
		logic [6:0] unused;
	} pbmc_ctrl_t;

	localparam logic [15:0]  CTRL_RST_VAL   = 16'h2100;
	localparam logic [6:0]   RSVD_ZERO      = 7'h00;

	typedef struct packed {
		logic [3:0] data;
		logic       valid;
	} pbmc_nib_t;

endpackage : pbmc_pkg

// ==== verilog/pbmc_coltest.sv ====
`timescale 1ns/10ps
module pbmc_coltest
	import pbmc_pkg::*;
(
	input  wire logic mclk,      // 100 MHz clock
	input  wire logic nrst,      // async reset, active low
	input  wire logic col_test,  // collision test mode
	input  wire logic tx_en,     // synchronised transmit enable
	input  wire logic line_col,  // collision from the line side
	output logic      col_reg    // collision to the MAC
);

	logic col_next;

	always_comb begin
		col_next = col_test ? tx_en : line_col; // RULE12 RULE13
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			col_reg <= 1'b0;
		end else begin
			col_reg <= col_next;
		end
	end

	// one bit time is one cycle at 100 Mb/s, so both limits are met
	AST_COL_ON: assert property (@(posedge mclk) disable iff (!nrst) // RULE12
		col_test && tx_en |=> col_reg)
		else $error("collision not raised in collision test");
	AST_COL_OFF: assert property (@(posedge mclk) disable iff (!nrst) // RULE13
		col_test && !tx_en |=> !col_reg)
		else $error("collision not dropped in collision test");
	COV_COL: cover property (@(posedge mclk) disable iff (!nrst)
		col_test && tx_en ##1 col_reg);

endmodule : pbmc_coltest

// ==== verilog/pbmc_top.sv ====
`timescale 1ns/10ps
// Summary of operation
// RULE1: writing one to bit 15 starts soft reset; reads one until finished
// RULE2: soft reset reloads the strap-derived settings as at power-up
// RULE3: loopback bit 14 returns MII transmit data into the receive path
// RULE4: after loopback is enabled receive data may be dead up to 500 us
// RULE5: with negotiation off, bit 13 selects 100 Mb/s or 10 Mb/s
// RULE6: negotiation enable bit 12 comes from a strap; set ignores 13 and 8
// RULE7: power down bit 11 stops the PHY; register access keeps working
// RULE8: isolate bit 10 cuts the port from MII; management still works
// RULE9: writing one to bit 9 restarts negotiation; ignored when disabled
// RULE10: restart reads one until negotiation begins; writing zero is harmless
// RULE11: with negotiation off, bit 8 selects full or half duplex
// RULE12: collision test bit 7 raises COL within 512 bit times of TX_EN
// RULE13: in collision test COL drops within 4 bit times of TX_EN falling
// RULE14: bits 6 to 0 ignore writes and read as zero
// RULE15: speed and duplex writes are kept while negotiation is enabled
module pbmc_top
	import pbmc_pkg::*;
#(
	parameter int LB_DEAD = LB_DEAD_CYCLES
) (
	input  wire logic        mclk,         // 100 MHz clock
	input  wire logic        nrst,         // async reset, active low
	input  wire logic        strap_an_en,  // negotiation enable strap pin
	input  wire logic        mgmt_wr_en,   // register write strobe
	input  wire logic        mgmt_rd_en,   // register read strobe
	input  wire logic [4:0]  mgmt_addr,    // register address
	input  wire logic [15:0] mgmt_wdata,   // register write data
	output logic      [15:0] mgmt_rdata,   // register read data
	input  wire logic        an_started,   // negotiation has begun, pulse
	input  wire logic        an_speed_100, // negotiated speed
	input  wire logic        an_full_dup,  // negotiated duplex
	input  wire logic [3:0]  mii_txd,      // MII transmit data pins
	input  wire logic        mii_tx_en,    // MII transmit enable pin
	input  wire logic [3:0]  line_rxd,     // receive data from line side
	input  wire logic        line_rx_dv,   // receive valid from line side
	input  wire logic        line_col,     // collision from line side
	output logic      [3:0]  mii_rxd,      // MII receive data
	output logic             mii_rx_dv,    // MII receive valid
	output logic             mii_col,      // MII collision
	output logic             mii_oe_n,     // MII output enable, low drives
	output logic      [3:0]  core_txd,     // transmit data to line side
	output logic             core_tx_en,   // transmit enable to line side
	output logic             core_reset,   // PHY core held in reset
	output logic             power_down,   // PHY powered down
	output logic             speed_100,    // active speed
	output logic             full_duplex,  // active duplex
	output logic             an_enable,    // negotiation enabled
	output logic             an_restart    // negotiation restart request
);

	pbmc_ctrl_t            ctrl_reg;
	pbmc_ctrl_t            ctrl_next;
	pbmc_ctrl_t            wr_view;
	logic [SRST_CNT_W-1:0] srst_cnt_reg;
	logic [SRST_CNT_W-1:0] srst_cnt_next;
	logic [DEAD_CNT_W-1:0] dead_cnt_reg;
	logic [DEAD_CNT_W-1:0] dead_cnt_next;
	logic                  lb_prev_reg;
	logic [1:0]            strap_sync_reg;
	pbmc_nib_t             tx_meta_reg;
	pbmc_nib_t             tx_sync_reg;
	pbmc_nib_t             rx_next;
	logic                  srst_busy;
	logic                  wr_hit;
	logic                  rd_hit;

	function automatic logic ctrl_hit(input logic [4:0] a);
		ctrl_hit = (a == ADDR_CTRL);
	endfunction : ctrl_hit

	assign wr_hit    = mgmt_wr_en && ctrl_hit(mgmt_addr);
	assign rd_hit    = mgmt_rd_en && ctrl_hit(mgmt_addr);
	assign srst_busy = (srst_cnt_reg != '0);
	assign wr_view   = pbmc_ctrl_t'(mgmt_wdata);

	// pin inputs pass two flip-flops before use
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			strap_sync_reg <= 2'h0;
			tx_meta_reg    <= '0;
			tx_sync_reg    <= '0;
		end else begin
			strap_sync_reg <= {strap_sync_reg[0], strap_an_en};
			tx_meta_reg    <= '{data: mii_txd, valid: mii_tx_en};
			tx_sync_reg    <= tx_meta_reg;
		end
	end

	// reset process; hardware reset also runs it to catch the strap
	always_comb begin
		srst_cnt_next = srst_cnt_reg;
		if (srst_busy) begin
			srst_cnt_next = srst_cnt_reg - 1'b1;
		end else if (wr_hit && wr_view.reset) begin
			srst_cnt_next = SRST_CNT_W'(SRST_CYCLES); // RULE1
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			srst_cnt_reg <= SRST_CNT_W'(SRST_CYCLES);
		end else begin
			srst_cnt_reg <= srst_cnt_next;
		end
	end

	always_comb begin
		ctrl_next       = ctrl_reg;
		ctrl_next.reset = srst_busy; // RULE1
		if (srst_cnt_reg == SRST_CNT_W'(1)) begin
			ctrl_next           = pbmc_ctrl_t'(CTRL_RST_VAL);
			ctrl_next.an_enable = strap_sync_reg[1]; // RULE2 RULE6
		end else if (wr_hit && !srst_busy && !wr_view.reset) begin
			ctrl_next.loopback    = wr_view.loopback; // RULE3
			ctrl_next.speed_100   = wr_view.speed_100; // RULE5 RULE15
			ctrl_next.an_enable   = wr_view.an_enable;
			ctrl_next.power_down  = wr_view.power_down; // RULE7
			ctrl_next.isolate     = wr_view.isolate; // RULE8
			ctrl_next.full_duplex = wr_view.full_duplex; // RULE11 RULE15
			ctrl_next.col_test    = wr_view.col_test;
		end else if (wr_hit && !srst_busy) begin
			ctrl_next.reset = 1'b1; // RULE1
		end
		if (an_started) begin
			ctrl_next.an_restart = 1'b0; // RULE10
		end
		if (wr_hit && !srst_busy && !wr_view.reset && wr_view.an_restart
				&& wr_view.an_enable) begin
			ctrl_next.an_restart = 1'b1; // RULE9
		end
		if (!ctrl_next.an_enable) begin
			ctrl_next.an_restart = 1'b0; // RULE9
		end
		ctrl_next.unused = RSVD_ZERO; // RULE14
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= pbmc_ctrl_t'(CTRL_RST_VAL);
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// receive dead window after loopback turns on
	always_comb begin
		dead_cnt_next = dead_cnt_reg;
		if (ctrl_reg.loopback && !lb_prev_reg) begin
			dead_cnt_next = DEAD_CNT_W'(LB_DEAD); // RULE4
		end else if (dead_cnt_reg != '0) begin
			dead_cnt_next = dead_cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dead_cnt_reg <= '0;
			lb_prev_reg  <= 1'b0;
		end else begin
			dead_cnt_reg <= dead_cnt_next;
			lb_prev_reg  <= ctrl_reg.loopback;
		end
	end

	always_comb begin
		rx_next = '{data: line_rxd, valid: line_rx_dv};
		if (ctrl_reg.loopback) begin
			rx_next = tx_sync_reg; // RULE3
			if (dead_cnt_reg != '0 || !lb_prev_reg) begin
				rx_next = '0; // RULE4
			end
		end
		if (ctrl_reg.isolate || ctrl_reg.power_down || srst_busy) begin
			rx_next = '0; // RULE7 RULE8
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mii_rxd    <= 4'h0;
			mii_rx_dv  <= 1'b0;
			mii_oe_n   <= 1'b1;
			core_txd   <= 4'h0;
			core_tx_en <= 1'b0;
		end else begin
			mii_rxd    <= rx_next.data;
			mii_rx_dv  <= rx_next.valid;
			mii_oe_n   <= ctrl_reg.isolate; // RULE8
			core_txd   <= tx_sync_reg.data;
			core_tx_en <= tx_sync_reg.valid && !ctrl_reg.loopback
				&& !ctrl_reg.isolate && !ctrl_reg.power_down; // RULE7 RULE8
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			speed_100   <= 1'b0;
			full_duplex <= 1'b0;
		end else begin
			speed_100   <= ctrl_reg.an_enable ? an_speed_100
				: ctrl_reg.speed_100; // RULE5 RULE6
			full_duplex <= ctrl_reg.an_enable ? an_full_dup
				: ctrl_reg.full_duplex; // RULE11 RULE6
		end
	end

	// management reads never stall, even in power down
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mgmt_rdata <= 16'h0000;
		end else if (rd_hit) begin
			mgmt_rdata <= {ctrl_reg[15:7], RSVD_ZERO}; // RULE7 RULE14
		end else if (mgmt_rd_en) begin
			mgmt_rdata <= 16'h0000;
		end
	end

	assign core_reset = srst_busy;
	assign power_down = ctrl_reg.power_down;
	assign an_enable  = ctrl_reg.an_enable;
	assign an_restart = ctrl_reg.an_restart;

	pbmc_coltest u_coltest (
		.mclk     (mclk),
		.nrst     (nrst),
		.col_test (ctrl_reg.col_test),
		.tx_en    (tx_sync_reg.valid),
		.line_col (line_col),
		.col_reg  (mii_col)
	);

	AST_SRST_HOLD: assert property (@(posedge mclk) disable iff (!nrst) // RULE1
		wr_hit && mgmt_wdata[BIT_RESET] && !srst_busy
		|=> (ctrl_reg.reset && core_reset)[*8])
		else $error("soft reset bit not held while reset runs");
	AST_SRST_RESTRAP: assert property (@(posedge mclk) disable iff (!nrst) // RULE2
		srst_cnt_reg == SRST_CNT_W'(1)
		|=> an_enable == $past(strap_sync_reg[1]) && !ctrl_reg.reset)
		else $error("strap not reloaded at end of reset");
	AST_LB_ROUTE: assert property (@(posedge mclk) disable iff (!nrst) // RULE3
		ctrl_reg.loopback && lb_prev_reg && dead_cnt_reg == '0
		&& !ctrl_reg.isolate && !ctrl_reg.power_down && !srst_busy
		|=> mii_rx_dv == $past(tx_sync_reg.valid))
		else $error("loopback data not returned");
	AST_LB_DEAD: assert property (@(posedge mclk) disable iff (!nrst) // RULE4
		$rose(ctrl_reg.loopback) |=> (!mii_rx_dv)[*8])
		else $error("receive valid during loopback dead time");
	AST_SPEED_FORCED: assert property (@(posedge mclk) disable iff (!nrst) // RULE5
		!ctrl_reg.an_enable |=> speed_100 == $past(ctrl_reg.speed_100))
		else $error("forced speed not applied");
	AST_AN_IGNORES: assert property (@(posedge mclk) disable iff (!nrst) // RULE6
		ctrl_reg.an_enable |=> speed_100 == $past(an_speed_100)
		&& full_duplex == $past(an_full_dup))
		else $error("negotiated result not applied");
	AST_PDOWN: assert property (@(posedge mclk) disable iff (!nrst) // RULE7
		ctrl_reg.power_down |=> !core_tx_en && !mii_rx_dv)
		else $error("traffic during power down");
	AST_ISOLATE: assert property (@(posedge mclk) disable iff (!nrst) // RULE8
		ctrl_reg.isolate |=> mii_oe_n && !mii_rx_dv && !core_tx_en)
		else $error("port not isolated");
	AST_RESTART_IGN: assert property (@(posedge mclk) disable iff (!nrst) // RULE9
		wr_hit && !srst_busy && !mgmt_wdata[BIT_AN_EN]
		&& !mgmt_wdata[BIT_RESET] |=> !an_restart)
		else $error("restart taken with negotiation disabled");
	AST_RESTART_HOLD: assert property (@(posedge mclk) disable iff (!nrst) // RULE10
		an_restart && !an_started && an_enable && !srst_busy
		&& !(wr_hit && (!mgmt_wdata[BIT_AN_EN] || mgmt_wdata[BIT_RESET]))
		|=> an_restart)
		else $error("restart cleared before negotiation began");
	AST_DUPLEX_FORCED: assert property (@(posedge mclk) disable iff (!nrst) // RULE11
		!ctrl_reg.an_enable |=> full_duplex == $past(ctrl_reg.full_duplex))
		else $error("forced duplex not applied");
	AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (!nrst) // RULE14
		rd_hit |=> mgmt_rdata[6:0] == RSVD_ZERO)
		else $error("reserved bits read nonzero");
	AST_KEEP_FORCED: assert property (@(posedge mclk) disable iff (!nrst) // RULE15
		wr_hit && !srst_busy && !mgmt_wdata[BIT_RESET]
		|=> ctrl_reg.speed_100 == $past(mgmt_wdata[BIT_SPEED])
		&& ctrl_reg.full_duplex == $past(mgmt_wdata[BIT_DUPLEX]))
		else $error("speed or duplex write lost");

	COV_SRST: cover property (@(posedge mclk) disable iff (!nrst)
		wr_hit && mgmt_wdata[BIT_RESET] && !srst_busy);
	COV_LB: cover property (@(posedge mclk) disable iff (!nrst)
		ctrl_reg.loopback && mii_rx_dv);
	COV_RESTART: cover property (@(posedge mclk) disable iff (!nrst)
		an_restart ##1 an_started ##1 !an_restart);
	COV_ISO: cover property (@(posedge mclk) disable iff (!nrst)
		ctrl_reg.isolate && mii_oe_n);

endmodule : pbmc_top

// ==== test/pbmc_mac.sv ====
`timescale 1ns/10ps
module pbmc_mac
	import pbmc_pkg::*;
(
	input  wire logic        mclk,  // clock
	output logic             wr_en, // write strobe
	output logic             rd_en, // read strobe
	output logic      [4:0]  addr,  // register address
	output logic      [15:0] wdata, // write data
	input  wire logic [15:0] rdata  // read data
);
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr  = 5'h1F;
		wdata = 16'h0000;
	end
	// one-cycle strobe; address and data are inverted once released
	task automatic xfer(input logic w, input logic [4:0] a,
		input logic [15:0] d, output logic [15:0] q);
		@(posedge mclk);
		#1;
		wr_en = w;
		rd_en = !w;
		addr  = a;
		wdata = d;
		@(posedge mclk);
		#1;
		q     = rdata;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr  = ~a;
		wdata = ~d;
	endtask : xfer
endmodule : pbmc_mac

// ==== test/test_phy_basic_mode_control.sv ====
`timescale 1ns/10ps
module test_phy_basic_mode_control;
	import pbmc_pkg::*;
	localparam int LB = 20;
	logic        mclk, nrst, strap_an_en, an_started;
	logic        an_speed_100, an_full_dup, mii_tx_en;
	logic        mgmt_wr_en, mgmt_rd_en, line_rx_dv, line_col;
	logic [4:0]  mgmt_addr;
	logic [15:0] mgmt_wdata, mgmt_rdata, q, d;
	logic [3:0]  mii_txd, line_rxd, mii_rxd, core_txd;
	logic        mii_rx_dv, mii_col, mii_oe_n, core_tx_en, core_reset;
	logic        power_down, speed_100, full_duplex, an_enable, an_restart;
	int          failures, checks_done, c;

	pbmc_mac i_pbmc_mac (.mclk(mclk), .wr_en(mgmt_wr_en),
		.rd_en(mgmt_rd_en), .addr(mgmt_addr), .wdata(mgmt_wdata),
		.rdata(mgmt_rdata));
	pbmc_top #(.LB_DEAD(LB)) i_pbmc_top (.mclk(mclk), .nrst(nrst),
		.strap_an_en(strap_an_en), .mgmt_wr_en(mgmt_wr_en),
		.mgmt_rd_en(mgmt_rd_en), .mgmt_addr(mgmt_addr),
		.mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
		.an_started(an_started), .an_speed_100(an_speed_100),
		.an_full_dup(an_full_dup), .mii_txd(mii_txd),
		.mii_tx_en(mii_tx_en), .line_rxd(line_rxd),
		.line_rx_dv(line_rx_dv), .line_col(line_col), .mii_rxd(mii_rxd),
		.mii_rx_dv(mii_rx_dv), .mii_col(mii_col), .mii_oe_n(mii_oe_n),
		.core_txd(core_txd), .core_tx_en(core_tx_en),
		.core_reset(core_reset), .power_down(power_down),
		.speed_100(speed_100), .full_duplex(full_duplex),
		.an_enable(an_enable), .an_restart(an_restart));

	always #5 mclk = ~mclk;

	task automatic stop_test;
		if (failures == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		i_pbmc_mac.xfer(1'b1, a, v, q);
	endtask : wr
	task automatic rd(input logic [4:0] a);
		i_pbmc_mac.xfer(1'b0, a, 16'h0000, q);
	endtask : rd
	// bounded wait for a level; running out ends the run
	task automatic wait_lvl(ref logic s, input logic v, input int lim);
		c = 0;
		while (s !== v && c < lim) begin
			@(posedge mclk);
			#1;
			c++;
		end
		chk({15'h0000, s}, {15'h0000, v});
		if (s !== v)
			stop_test();
	endtask : wait_lvl
	task automatic step;
		@(posedge mclk);
		#1;
	endtask : step

	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		strap_an_en = 1'b1;
		an_started = 1'b0;
		an_speed_100 = 1'b1;
		an_full_dup = 1'b0;
		mii_txd = 4'h0;
		mii_tx_en = 1'b0;
		line_rxd = 4'hA;
		line_rx_dv = 1'b1;
		line_col = 1'b0;
		failures = 0;
		checks_done = 0;
		repeat (16) @(posedge mclk);
		#1;
		nrst = 1'b1;
		rd(5'h00);
		chk({15'h0000, q[15]}, 16'h0001);
		wait_lvl(core_reset, 1'b0, SRST_CYCLES + 8);
		rd(5'h00);
		chk(q, 16'h3100);
		chk({15'h0000, an_enable}, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			d = 16'h0000;
			d[13] = i[1];
			d[8] = i[0];
			wr(5'h00, d | 16'h007F);
			step();
			chk({14'h0000, speed_100, full_duplex}, 16'(i));
			rd(5'h00);
			chk(q, d);
		end
		chk({14'h0000, mii_oe_n, mii_rx_dv}, 16'h0001);
		chk({12'h000, mii_rxd}, 16'h000A);
		wr(5'h00, 16'h1000);
		step();
		chk({14'h0000, speed_100, full_duplex}, 16'h0002);
		rd(5'h00);
		chk(q, 16'h1000);
		wr(5'h00, 16'h0200);
		rd(5'h00);
		chk(q, 16'h0000);
		chk({15'h0000, an_restart}, 16'h0000);
		wr(5'h00, 16'h1200);
		chk({15'h0000, an_restart}, 16'h0001);
		wr(5'h00, 16'h1000);
		rd(5'h00);
		chk(q, 16'h1200);
		an_started = 1'b1;
		step();
		an_started = 1'b0;
		rd(5'h00);
		chk(q, 16'h1000);
		wr(5'h00, 16'h0800);
		chk({15'h0000, power_down}, 16'h0001);
		rd(5'h00);
		chk(q, 16'h0800);
		wr(5'h00, 16'h0400);
		step();
		chk({14'h0000, mii_oe_n, mii_rx_dv}, 16'h0002);
		rd(5'h00);
		chk(q, 16'h0400);
		mii_txd = 4'hC;
		mii_tx_en = 1'b1;
		wr(5'h00, 16'h6000);
		wait_lvl(mii_rx_dv, 1'b1, LB + 10);
		chk({15'h0000, c >= LB}, 16'h0001);
		chk({12'h000, mii_rxd}, 16'h000C);
		mii_txd = 4'h3;
		repeat (3) step();
		chk({7'h00, core_txd, core_tx_en, mii_rxd}, 16'h0063);
		mii_tx_en = 1'b0;
		wr(5'h00, 16'h2080);
		repeat (4) step();
		mii_tx_en = 1'b1;
		wait_lvl(mii_col, 1'b1, COL_ON_BIT_TIMES);
		chk({11'h000, core_tx_en, core_txd}, 16'h0013);
		mii_tx_en = 1'b0;
		wait_lvl(mii_col, 1'b0, COL_OFF_BIT_TIMES);
		wr(5'h01, 16'hFFFF);
		rd(5'h01);
		chk(q, 16'h0000);
		rd(5'h00);
		chk(q, 16'h2080);
		strap_an_en = 1'b0;
		wr(5'h00, 16'h8000);
		rd(5'h00);
		chk({15'h0000, q[15]}, 16'h0001);
		wait_lvl(core_reset, 1'b0, SRST_CYCLES + 8);
		rd(5'h00);
		chk(q, 16'h2100);
		stop_test();
	end
endmodule : test_phy_basic_mode_control
